// File: src/cdfa_defines.vh
// constants for the double-fetch, address-format and stack unit
`ifndef CDFA_DEFINES_VH
`define CDFA_DEFINES_VH
// register word addresses (one Avalon word per register)
`define CDFA_REG_CTRL      4'h0
`define CDFA_REG_ADDR_LO   4'h1
`define CDFA_REG_ADDR_HI   4'h2
`define CDFA_REG_DATA0     4'h3
`define CDFA_REG_DATA1     4'h4
`define CDFA_REG_STATUS    4'h5
`define CDFA_REG_IRQ_STAT  4'h6
`define CDFA_REG_IRQ_MASK  4'h7
`define CDFA_REG_STK_PTR   4'h8
`define CDFA_REG_STK_CMD   4'h9
`define CDFA_REG_STK_CW    4'ha
`define CDFA_REG_STK_MW    4'hb
// ctrl bits
`define CDFA_CTRL_FETCH    0
// stack command bits
`define CDFA_STK_PUSH      0
`define CDFA_STK_POP       1
// irq bits
`define CDFA_IRQ_DONE      0
`define CDFA_IRQ_OVF       1
`define CDFA_IRQ_UNF       2
`define CDFA_IRQ_W         3
// status bits
`define CDFA_ST_BUSY       0
`define CDFA_ST_LONG       1
`define CDFA_ST_DBL        2
// stack header layout: word 0 max words, word 1 consumed words
`define CDFA_HDR_MW        20'h00000
`define CDFA_HDR_CW        20'h00001
`define CDFA_SHORT_MASK    20'h0ffff
`endif

// File: src/cdfa_core.v
// double-word fetch, short/long address format and stack upkeep unit
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
//
// Overview of operation
// - one double-pull read request fetches two consecutive words.
// - double line false on first response makes us issue second read.
// - short format limits generated addresses to 16 bits, except the consumed-word write-back at hdr_base + 1.
// - long format keeps 32-bit addresses, drives only 20 physical bits.
// - panel switch selects format; long position lights indicator.
// - a long address spans two words: 4 high bits, 16 low bits.
// - frame length is read from the first word of a pushed frame, the last word of a popped one.
// - one stack per level, found through the stack register.
// - hardware updates consumed words; max words set by software only.
// - overflow or underflow of the stack raises a trap.
`include "cdfa_defines.vh"
module cdfa_core (
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   // avalon-mm slave
   input  wire [3:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   output reg  [31:0] o_avs_readdata,
   output reg         o_avs_waitrequest,
   // panel
   input  wire        i_format_switch_long,
   output reg         o_long_format_lamp,
   // system bus memory port
   output reg         o_mem_req,
   output reg         o_mem_double_pull,
   output reg  [19:0] o_mem_addr,
   output reg         o_mem_write,
   output reg  [15:0] o_mem_wdata,
   input  wire        i_mem_ack,
   input  wire        i_mem_resp,
   input  wire        i_mem_double,
   input  wire [15:0] i_mem_rdata,
   // traps and interrupt
   output reg         o_trap_overflow,
   output reg         o_trap_underflow,
   output reg         o_irq
);

////////////////////////////////////////////////////////////////////////////////
localparam [9:0] S_IDLE  = 10'h001;
localparam [9:0] S_REQ   = 10'h002;
localparam [9:0] S_RSP1  = 10'h004;
localparam [9:0] S_RSP2  = 10'h008;
localparam [9:0] S_REQ2  = 10'h010;
localparam [9:0] S_DONE  = 10'h020;
localparam [9:0] S_HDR   = 10'h040;
localparam [9:0] S_CHECK = 10'h080;
localparam [9:0] S_LEN   = 10'h100;
localparam [9:0] S_WRCW  = 10'h200;

// address formed in the active format
function [19:0] fmt_addr;
   input        long_fmt;
   input [31:0] a;
   begin
      if (long_fmt)
         fmt_addr = a[19:0];
      else
         fmt_addr = a[19:0] & `CDFA_SHORT_MASK;
   end
endfunction

// switch synchroniser: first stage is read only by the second
reg        sw_meta;
reg        long_fmt;
reg [9:0]  state;
reg [31:0] addr;
reg [15:0] data0;
reg [15:0] data1;
reg        got_double;
reg [3:0]  irq_stat;
reg [3:0]  irq_mask;
reg [31:0] stk_ptr;
reg [15:0] stk_mw;
reg [15:0] stk_cw;
reg [15:0] frame_len;
reg        op_push;
reg        op_stack;
reg [3:0]  ev;
reg        rd_pend;
reg        mem_busy;

wire        busy = (state != S_IDLE);
wire [17:0] cw_sum = {2'h0, stk_cw} + {2'h0, frame_len};
wire [19:0] hdr_base = fmt_addr(long_fmt, stk_ptr);

////////////////////////////////////////////////////////////////////////////////
always @(posedge i_ref_clk) begin
   if (!i_rst_n) begin
      sw_meta  <= 1'b0;
      long_fmt <= 1'b0;
   end else begin
      sw_meta  <= i_format_switch_long;
      long_fmt <= sw_meta;
   end
end

////////////////////////////////////////////////////////////////////////////////
// memory sequencer
always @(posedge i_ref_clk) begin
   if (!i_rst_n) begin
      state             <= S_IDLE;
      o_mem_req         <= 1'b0;
      o_mem_double_pull <= 1'b0;
      o_mem_addr        <= 20'h00000;
      o_mem_write       <= 1'b0;
      o_mem_wdata       <= 16'h0000;
      data0             <= 16'h0000;
      data1             <= 16'h0000;
      got_double        <= 1'b0;
      stk_mw            <= 16'h0000;
      stk_cw            <= 16'h0000;
      frame_len         <= 16'h0000;
      op_push           <= 1'b0;
      op_stack          <= 1'b0;
      mem_busy          <= 1'b0;
      ev                <= 4'h0;
      o_trap_overflow   <= 1'b0;
      o_trap_underflow  <= 1'b0;
   end else begin
      ev               <= 4'h0;
      o_trap_overflow  <= 1'b0;
      o_trap_underflow <= 1'b0;
      case (state)
         S_IDLE: begin
            if (i_avs_write && o_avs_waitrequest == 1'b0) begin
               if (i_avs_address == `CDFA_REG_CTRL &&
                   i_avs_writedata[`CDFA_CTRL_FETCH]) begin
                  o_mem_req         <= 1'b1;
                  o_mem_double_pull <= 1'b1;
                  o_mem_write       <= 1'b0;
                  o_mem_addr        <= fmt_addr(long_fmt, addr);
                  op_stack          <= 1'b0;
                  state             <= S_REQ;
               end else if (i_avs_address == `CDFA_REG_STK_CMD &&
                            |i_avs_writedata[1:0]) begin
                  // header located through the stack register
                  op_push           <= i_avs_writedata[`CDFA_STK_PUSH];
                  op_stack          <= 1'b1;
                  o_mem_req         <= 1'b1;
                  o_mem_double_pull <= 1'b1;
                  o_mem_write       <= 1'b0;
                  o_mem_addr        <= hdr_base;
                  state             <= S_REQ;
               end
            end
         end
         S_REQ: begin
            if (i_mem_ack) begin
               o_mem_req <= 1'b0;
               // pull marks the request cycle only
               o_mem_double_pull <= 1'b0;
               state     <= S_RSP1;
            end
         end
         S_RSP1: begin
            if (i_mem_resp) begin
               data0             <= i_mem_rdata;
               got_double        <= i_mem_double;
               o_mem_double_pull <= 1'b0;
               // double line true means the second word follows
               if (i_mem_double) begin
                  state <= S_RSP2;
               end else begin
                  o_mem_req  <= 1'b1;
                  o_mem_addr <= fmt_addr(long_fmt, {12'h000, o_mem_addr} + 32'h1);
                  state      <= S_REQ2;
               end
            end
         end
         S_REQ2: begin
            if (i_mem_ack) begin
               o_mem_req <= 1'b0;
               state     <= S_RSP2;
            end
         end
         S_RSP2: begin
            if (i_mem_resp) begin
               data1 <= i_mem_rdata;
               if (op_stack && !o_mem_write && !mem_busy) begin
                  stk_mw <= data0;
                  stk_cw <= i_mem_rdata;
                  state  <= op_push ? S_LEN : S_CHECK;
                  if (op_push) begin
                     // frame length from first word of new frame
                     o_mem_req         <= 1'b1;
                     o_mem_addr        <= fmt_addr(long_fmt, {12'h000, hdr_base}
                                          + {16'h0000, i_mem_rdata} + 32'h2);
                     mem_busy          <= 1'b1;
                  end else begin
                     // top frame length word is the last consumed word
                     o_mem_req         <= 1'b1;
                     o_mem_addr        <= fmt_addr(long_fmt, {12'h000, hdr_base}
                                          + {16'h0000, i_mem_rdata} + 32'h1);
                     mem_busy          <= 1'b1;
                     state             <= S_LEN;
                  end
               end else begin
                  state <= S_DONE;
               end
            end
         end
         S_LEN: begin
            if (i_mem_ack)
               o_mem_req <= 1'b0;
            if (i_mem_resp) begin
               frame_len <= i_mem_rdata;
               state     <= S_CHECK;
            end
         end
         S_CHECK: begin
            // overflow against max words, underflow below zero or on an empty stack
            if (op_push && (cw_sum > {2'h0, stk_mw})) begin
               o_trap_overflow <= 1'b1;
               ev[`CDFA_IRQ_OVF] <= 1'b1;
               state <= S_DONE;
            end else if (!op_push && (frame_len > stk_cw || stk_cw == 16'h0000)) begin
               o_trap_underflow <= 1'b1;
               ev[`CDFA_IRQ_UNF] <= 1'b1;
               state <= S_DONE;
            end else begin
               // only the consumed count is written back
               o_mem_req   <= 1'b1;
               o_mem_write <= 1'b1;
               o_mem_addr  <= hdr_base + `CDFA_HDR_CW;
               o_mem_wdata <= op_push ? cw_sum[15:0] : (stk_cw - frame_len);
               stk_cw      <= op_push ? cw_sum[15:0] : (stk_cw - frame_len);
               state       <= S_WRCW;
            end
         end
         S_WRCW: begin
            if (i_mem_ack) begin
               o_mem_req   <= 1'b0;
               o_mem_write <= 1'b0;
               state       <= S_DONE;
            end
         end
         S_DONE: begin
            mem_busy        <= 1'b0;
            ev[`CDFA_IRQ_DONE] <= 1'b1;
            state           <= S_IDLE;
         end
         default: state <= S_IDLE;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle on every access so readdata is registered
always @(posedge i_ref_clk) begin
   if (!i_rst_n) begin
      o_avs_waitrequest  <= 1'b1;
      o_avs_readdata     <= 32'h00000000;
      rd_pend            <= 1'b0;
      addr               <= 32'h00000000;
      irq_stat           <= 4'h0;
      irq_mask           <= 4'h0;
      stk_ptr            <= 32'h00000000;
      o_irq              <= 1'b0;
      o_long_format_lamp <= 1'b0;
   end else begin
      o_long_format_lamp <= long_fmt;
      o_irq <= |(irq_stat & irq_mask);
      o_avs_waitrequest <= 1'b1;
      rd_pend <= 1'b0;
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest && !rd_pend) begin
         o_avs_waitrequest <= 1'b0;
         rd_pend           <= 1'b1;
         case (i_avs_address)
            `CDFA_REG_ADDR_LO: o_avs_readdata <= {16'h0000, addr[15:0]};
            // long address high word holds 4 bits
            `CDFA_REG_ADDR_HI: o_avs_readdata <= {28'h0000000, addr[19:16]};
            `CDFA_REG_DATA0:   o_avs_readdata <= {16'h0000, data0};
            `CDFA_REG_DATA1:   o_avs_readdata <= {16'h0000, data1};
            `CDFA_REG_STATUS:  o_avs_readdata <= {29'h0, got_double, long_fmt, busy};
            `CDFA_REG_IRQ_STAT: o_avs_readdata <= {28'h0, irq_stat};
            `CDFA_REG_IRQ_MASK: o_avs_readdata <= {28'h0, irq_mask};
            `CDFA_REG_STK_PTR: o_avs_readdata <= stk_ptr;
            `CDFA_REG_STK_CW:  o_avs_readdata <= {16'h0000, stk_cw};
            `CDFA_REG_STK_MW:  o_avs_readdata <= {16'h0000, stk_mw};
            default:           o_avs_readdata <= 32'h00000000;
         endcase
      end
      if (i_avs_write && !o_avs_waitrequest && !busy) begin
         case (i_avs_address)
            `CDFA_REG_ADDR_LO: addr[15:0] <= i_avs_writedata[15:0];
            // only 20 physical bits kept in long format
            `CDFA_REG_ADDR_HI: addr[31:16] <= long_fmt ?
                                  {12'h000, i_avs_writedata[3:0]} : 16'h0000;
            `CDFA_REG_IRQ_MASK: irq_mask <= i_avs_writedata[3:0];
            `CDFA_REG_STK_PTR: stk_ptr <= i_avs_writedata;
            default: ;
         endcase
      end
      // set wins over read-clear
      if (i_avs_read && !o_avs_waitrequest && i_avs_address == `CDFA_REG_IRQ_STAT)
         irq_stat <= ev;
      else
         irq_stat <= irq_stat | ev;
   end
end

endmodule // cdfa_core

// File: verif/cdfa_core_checker.sv
// assertions on the ports of the double-fetch unit
`timescale 1ns/1ns
module cdfa_checker (
   input wire        i_ref_clk,
   input wire        i_rst_n,
   input wire        i_avs_read,
   input wire        i_avs_write,
   input wire        o_avs_waitrequest,
   input wire        i_format_switch_long,
   input wire        o_long_format_lamp,
   input wire        o_mem_req,
   input wire        o_mem_double_pull,
   input wire [19:0] o_mem_addr,
   input wire        i_mem_ack,
   input wire        i_mem_resp,
   input wire        i_mem_double,
   input wire        o_trap_overflow
);
   logic        pend;
   logic [19:0] base;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // a taken double pull arms the fallback check
   always @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         pend <= 1'b0;
         base <= 20'h00000;
      end else if (o_mem_req && i_mem_ack && o_mem_double_pull) begin
         pend <= 1'b1;
         base <= o_mem_addr;
      end else if (i_mem_resp) begin
         pend <= 1'b0;
      end
   end
   ////////////////////////////////////////
   sequence s_one; pend && i_mem_resp && !i_mem_double; endsequence
   property p_pull; o_mem_double_pull |-> o_mem_req; endproperty
   a_pull: assert property (p_pull) else $error("pull without request");
   property p_again; s_one |-> ##[1:40] o_mem_req && !o_mem_double_pull; endproperty
   a_again: assert property (p_again) else $error("no second read");
   property p_next;
      s_one |-> ##[1:40] o_mem_req && o_mem_addr == base + 20'h00001;
   endproperty
   a_next: assert property (p_next) else $error("second read address");
   property p_short; o_mem_req && !o_long_format_lamp |-> o_mem_addr[19:16] == 4'h0; endproperty
   a_short: assert property (p_short) else $error("short address too wide");
   property p_lamp;
      $stable(i_format_switch_long) [*6] |-> o_long_format_lamp == i_format_switch_long;
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp not following switch");
   property p_trap; o_trap_overflow |=> !o_trap_overflow; endproperty
   a_trap: assert property (p_trap) else $error("trap pulse too long");
   property p_ans; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer late");
   property p_once; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
   a_once: assert property (p_once) else $error("bus answer too long");
   c_dbl: cover property (pend && i_mem_resp && i_mem_double);
   c_one: cover property (s_one);
   c_ovf: cover property (o_trap_overflow);
endmodule // cdfa_checker
bind cdfa_core cdfa_checker i_chk (
   .i_ref_clk            (i_ref_clk),
   .i_rst_n              (i_rst_n),
   .i_avs_read           (i_avs_read),
   .i_avs_write          (i_avs_write),
   .o_avs_waitrequest    (o_avs_waitrequest),
   .i_format_switch_long (i_format_switch_long),
   .o_long_format_lamp   (o_long_format_lamp),
   .o_mem_req            (o_mem_req),
   .o_mem_double_pull    (o_mem_double_pull),
   .o_mem_addr           (o_mem_addr),
   .i_mem_ack            (i_mem_ack),
   .i_mem_resp           (i_mem_resp),
   .i_mem_double         (i_mem_double),
   .o_trap_overflow      (o_trap_overflow)
);

// File: verif/cdfa_mem_model.sv
// memory controller model for the system bus port
`timescale 1ns/1ns
module cdfa_mem_model (
   input  wire         i_clk,
   input  wire         i_req,
   input  wire         i_pull,
   input  wire         i_wr,
   input  wire         i_cap,
   input  wire         i_slow,
   input  wire  [19:0] i_addr,
   input  wire  [15:0] i_wdata,
   output logic        o_ack = 1'b0,
   output logic        o_resp = 1'b0,
   output logic        o_dbl = 1'b0,
   output logic [15:0] o_rdata = 16'h0000
);
   logic [15:0] mem [0:255];
   logic [19:0] addr = 20'h00000;
   logic [2:0]  dly = 3'h0;
   logic        busy = 1'b0;
   logic        two = 1'b0;
   int          n_req = 0;
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_resp <= 1'b0;
      o_dbl <= 1'b0;
      // data lines carry junk outside a response
      o_rdata <= ~o_rdata;
      if (busy) begin
         o_resp <= 1'b1;
         o_dbl <= two;
         o_rdata <= mem[addr[7:0]] ^ {addr[19:16], 12'h000};
         busy <= two;
         two <= 1'b0;
         addr <= addr + 20'h00001;
      end else if (i_req && !o_ack && dly != 3'h0) begin
         dly <= dly - 3'h1;
      end else if (i_req && !o_ack) begin
         o_ack <= 1'b1;
         dly <= i_slow ? 3'h4 : 3'h0;
         if (i_wr) begin
            mem[i_addr[7:0]] <= i_wdata;
         end else begin
            busy <= 1'b1;
            two <= i_pull && i_cap;
            addr <= i_addr;
            n_req <= n_req + 1;
         end
      end
   end
endmodule // cdfa_mem_model

// File: verif/test_cpu_double_fetch_addressing.sv
// bench for the double-fetch, address-format and stack unit
`timescale 1ns/1ns
module test_cpu_double_fetch_addressing;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [3:0]  i_avs_address = 4'h0;
   logic [31:0] i_avs_writedata = 32'h00000000;
   logic        i_format_switch_long = 1'b0;
   logic        cap = 1'b1;
   logic        slow = 1'b0;
   logic [31:0] o_avs_readdata, rd;
   logic [19:0] o_mem_addr;
   logic [15:0] o_mem_wdata, i_mem_rdata;
   logic        o_avs_waitrequest, o_long_format_lamp, o_mem_req, o_mem_double_pull;
   logic        o_mem_write, i_mem_ack, i_mem_resp, i_mem_double;
   logic        o_trap_overflow, o_trap_underflow, o_irq;
   int          fails = 0;
   int          num_checks = 0;
   int          n_ovf = 0;
   int          n_unf = 0;
   always #25 i_ref_clk = ~i_ref_clk;
   // trap pulses last one cycle, so they are counted as they pass
   always @(posedge i_ref_clk) begin
      if (o_trap_overflow === 1'b1)
         n_ovf++;
      if (o_trap_underflow === 1'b1)
         n_unf++;
   end
   cdfa_core i_dut (
      .i_ref_clk            (i_ref_clk),
      .i_rst_n              (i_rst_n),
      .i_avs_address        (i_avs_address),
      .i_avs_read           (i_avs_read),
      .i_avs_write          (i_avs_write),
      .i_avs_writedata      (i_avs_writedata),
      .o_avs_readdata       (o_avs_readdata),
      .o_avs_waitrequest    (o_avs_waitrequest),
      .i_format_switch_long (i_format_switch_long),
      .o_long_format_lamp   (o_long_format_lamp),
      .o_mem_req            (o_mem_req),
      .o_mem_double_pull    (o_mem_double_pull),
      .o_mem_addr           (o_mem_addr),
      .o_mem_write          (o_mem_write),
      .o_mem_wdata          (o_mem_wdata),
      .i_mem_ack            (i_mem_ack),
      .i_mem_resp           (i_mem_resp),
      .i_mem_double         (i_mem_double),
      .i_mem_rdata          (i_mem_rdata),
      .o_trap_overflow      (o_trap_overflow),
      .o_trap_underflow     (o_trap_underflow),
      .o_irq                (o_irq)
   );
   cdfa_mem_model i_mem (.i_clk(i_ref_clk), .i_req(o_mem_req), .i_pull(o_mem_double_pull),
      .i_wr(o_mem_write), .i_cap(cap), .i_slow(slow), .i_addr(o_mem_addr),
      .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_resp(i_mem_resp),
      .o_dbl(i_mem_double), .o_rdata(i_mem_rdata));
   ////////////////////////////////////////
   task automatic conclude();
      if (fails == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   // one edge passes first so back-to-back calls never reassign in one step
   task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
      int k;
      @(posedge i_ref_clk);
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_address <= ad;
      i_avs_writedata <= wd;
      k = 0;
      do begin
         @(posedge i_ref_clk);
         k++;
      end while (o_avs_waitrequest !== 1'b0 && k < 20);
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      if (k >= 20) begin
         fails++;
         conclude();
      end
   endtask
   task automatic idle();
      int k;
      k = 0;
      do begin
         bus(1'b0, 4'h5, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 50);
      if (k >= 50) begin
         fails++;
         conclude();
      end
   endtask
   function automatic logic [15:0] word(input logic [19:0] a);
      return i_mem.mem[a[7:0]] ^ {a[19:16], 12'h000};
   endfunction
   ////////////////////////////////////////
   task automatic t_regs();
      bus(1'b0, 4'h5, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 4'hf, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_fetch(input logic lng, input logic [3:0] hi, input logic [15:0] lo,
                          input logic dbl);
      logic [19:0] a;
      int n0;
      a = lng ? {hi, lo} : {4'h0, lo};
      n0 = i_mem.n_req;
      i_format_switch_long <= lng;
      cap <= dbl;
      slow <= !dbl;
      repeat (8) @(posedge i_ref_clk);
      chk({31'h0, o_long_format_lamp}, {31'h0, lng});
      bus(1'b0, 4'h5, 32'h0);
      chk({31'h0, rd[1]}, {31'h0, lng});
      bus(1'b1, 4'h1, {16'h0, lo});
      bus(1'b1, 4'h2, {28'h0, hi});
      bus(1'b1, 4'h0, 32'h1);
      idle();
      bus(1'b0, 4'h3, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, word(a)});
      bus(1'b0, 4'h4, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, word(a + 20'h00001)});
      chk(32'(i_mem.n_req - n0), dbl ? 32'h1 : 32'h2);
   endtask
   // high address bits left from long format must not reach memory in short format
   task automatic t_mask();
      i_format_switch_long <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
      bus(1'b1, 4'h1, 32'h30);
      bus(1'b1, 4'h0, 32'h1);
      idle();
      bus(1'b0, 4'h3, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, word(20'h00030)});
      bus(1'b0, 4'h4, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, word(20'h00031)});
   endtask
   task automatic t_stack();
      i_mem.mem[8'h40] = 16'h000a;
      i_mem.mem[8'h41] = 16'h0000;
      i_mem.mem[8'h42] = 16'h0003;
      i_mem.mem[8'h44] = 16'h0003;
      i_mem.mem[8'h45] = 16'h0008;
      bus(1'b1, 4'h7, 32'h0);
      bus(1'b0, 4'h6, 32'h0);
      bus(1'b1, 4'h8, 32'h40);
      bus(1'b1, 4'h9, 32'h1);
      idle();
      chk({16'h0, i_mem.mem[8'h41]}, 32'h3);
      bus(1'b0, 4'ha, 32'h0);
      chk(rd, 32'h3);
      chk(32'(n_ovf + n_unf), 32'h0);
      // 3 + 8 words exceed the limit of 10
      bus(1'b1, 4'h9, 32'h1);
      idle();
      chk(32'(n_ovf), 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      bus(1'b1, 4'h7, 32'h7);
      repeat (3) @(posedge i_ref_clk);
      chk({31'h0, o_irq}, 32'h1);
      bus(1'b0, 4'h6, 32'h0);
      chk(rd & 32'h6, 32'h2);
      chk({16'h0, i_mem.mem[8'h41]}, 32'h3);
      bus(1'b1, 4'h7, 32'h6);
      repeat (3) @(posedge i_ref_clk);
      chk({31'h0, o_irq}, 32'h0);
      bus(1'b1, 4'h9, 32'h2);
      idle();
      chk({16'h0, i_mem.mem[8'h41]}, 32'h0);
      bus(1'b1, 4'h9, 32'h2);
      idle();
      bus(1'b0, 4'h6, 32'h0);
      chk(rd & 32'h6, 32'h4);
      chk(32'(n_unf), 32'h1);
   endtask
   ////////////////////////////////////////
   initial begin
      for (int k = 0; k < 256; k++)
         i_mem.mem[k] = {8'h5a, 8'(k)};
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_fetch(1'b0, 4'h5, 16'h0010, 1'b1);
      t_fetch(1'b1, 4'h5, 16'hffff, 1'b0);
      t_fetch(1'b1, 4'h3, 16'h0020, 1'b1);
      t_mask();
      t_stack();
      conclude();
   end
endmodule // test_cpu_double_fetch_addressing
